// ### design/aab_defines.vh
/*
  constants for the accumulator add and bit-operation datapath:
  opcode patterns, field positions, flag positions, timing counts.
  assumes a 14-bit instruction word and an 8-bit data path.
*/
`ifndef AAB_DEFINES_VH
`define AAB_DEFINES_VH

// instruction word fields
`define AAB_OP_W 14
`define AAB_FILE_LSB 0
`define AAB_FILE_MSB 6
`define AAB_DEST_BIT 7
`define AAB_BITSEL_LSB 7
`define AAB_BITSEL_MSB 9
`define AAB_LIT_LSB 0
`define AAB_LIT_MSB 7

// opcode patterns in the upper bits
`define AAB_TOP6_ADDF 6'h07
`define AAB_TOP6_ANDF 6'h05
`define AAB_TOP4_BITCLR 4'h4
`define AAB_TOP4_BITSET 4'h5
`define AAB_TOP4_SKIPZERO 4'h6
`define AAB_TOP4_SKIPONE 4'h7
`define AAB_TOP5_ADDLIT 5'h1f
`define AAB_TOP6_ANDLIT 6'h39

// flag positions in the status output
`define AAB_FLAG_C 0
`define AAB_FLAG_HC 1
`define AAB_FLAG_Z 2

// reset values
`define AAB_ACC_RESET 8'h00
`define AAB_FLAGS_RESET 3'h0

// one instruction cycle is four oscillator periods
`define AAB_PHASES_PER_CYCLE 4
`define AAB_PHASE_LAST 2'h3

`endif

// ### design/aab_alu.v
/*
  combinational 8-bit add / and unit with carry, half-carry and zero.
  assumes operands are stable over the instruction cycle.
*/
`timescale 1ns/1ns
module aab_alu (
  input wire [7:0] a_in, // first operand (accumulator)
  input wire [7:0] b_in, // second operand (literal or file)
  input wire do_and, // 1 selects and, 0 selects add
  output reg [7:0] result, // operation result
  output reg carry_out, // carry out of bit 7
  output reg half_out, // carry out of bit 3
  output reg zero_out // result is zero
);
  reg [8:0] sum_full;
  reg [4:0] sum_low;

  // add or and, flag terms
  always @*
  begin
    sum_full = {1'b0, a_in} + {1'b0, b_in};
    sum_low = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]};
    result = do_and ? (a_in & b_in) : sum_full[7:0];
    carry_out = sum_full[8];
    half_out = sum_low[4];
    zero_out = (result == 8'h00);
  end
endmodule // aab_alu

// ### design/aab_core.v
/*
  execution datapath for eight instructions of an 8-bit accumulator core,
  holding the accumulator, the flags and a 128-byte file register array.
  assumes instr and instr_valid are held by fetch logic for a whole
  instruction cycle and sampled at the last of its four phases.
*/
`timescale 1ns/1ns
`include "aab_defines.vh"
module aab_core (
  input wire clock, // core clock, 50 MHz
  input wire resetn, // asynchronous reset, active low
  input wire [13:0] instr, // instruction word for this cycle
  input wire instr_valid, // instruction present this cycle
  output reg [7:0] acc_out, // accumulator
  output reg [2:0] flags_out, // {zero, half-carry, carry}
  output reg cycle_end, // pulse in the clock after the last phase of each cycle
  output reg skip_active, // current cycle is a forced no-op
  output reg exec_done, // pulse: an instruction took effect
  output reg [6:0] wr_addr, // last file address written
  output reg [7:0] wr_data, // last file data written
  output reg wr_strobe // pulse: file register written
);
  reg [1:0] phase_reg;
  reg skip_reg;
  reg [7:0] file_mem [0:127];
  reg [7:0] acc_next;
  reg [2:0] flags_next;
  reg skip_next;
  reg file_we;
  reg [7:0] file_wdata;
  reg did_exec;
  wire [6:0] fsel;
  wire [2:0] bsel;
  wire [7:0] lit;
  wire dest;
  wire [7:0] fval;
  wire tested_bit;
  wire is_addf;
  wire is_andf;
  wire is_bclr;
  wire is_bset;
  wire is_skz;
  wire is_sko;
  wire is_addl;
  wire is_andl;
  wire use_lit;
  wire [7:0] alu_res;
  wire alu_c;
  wire alu_hc;
  wire alu_z;
  wire last_phase;

  // operand fields; d and the low bit of b both sit at instr[7],
  // so only the decode tells which meaning applies
  assign fsel = instr[`AAB_FILE_MSB:`AAB_FILE_LSB];
  assign bsel = instr[`AAB_BITSEL_MSB:`AAB_BITSEL_LSB];
  assign lit = instr[`AAB_LIT_MSB:`AAB_LIT_LSB];
  assign dest = instr[`AAB_DEST_BIT];
  assign fval = file_mem[fsel];
  assign tested_bit = fval[bsel];
  assign last_phase = (phase_reg == `AAB_PHASE_LAST);

  // opcode decode
  assign is_addf = (instr[13:8] == `AAB_TOP6_ADDF);
  assign is_andf = (instr[13:8] == `AAB_TOP6_ANDF);
  assign is_bclr = (instr[13:10] == `AAB_TOP4_BITCLR);
  assign is_bset = (instr[13:10] == `AAB_TOP4_BITSET);
  assign is_skz = (instr[13:10] == `AAB_TOP4_SKIPZERO);
  assign is_sko = (instr[13:10] == `AAB_TOP4_SKIPONE);
  assign is_addl = (instr[13:9] == `AAB_TOP5_ADDLIT);
  assign is_andl = (instr[13:8] == `AAB_TOP6_ANDLIT);
  assign use_lit = is_addl | is_andl;

  aab_alu u_alu (
    .a_in(acc_out),
    .b_in(use_lit ? lit : fval),
    .do_and(is_andl | is_andf),
    .result(alu_res),
    .carry_out(alu_c),
    .half_out(alu_hc),
    .zero_out(alu_z)
  );

  // execute decision, only on the last phase of a cycle
  always @*
  begin
    acc_next = acc_out;
    flags_next = flags_out;
    skip_next = skip_reg;
    file_we = 1'b0;
    file_wdata = fval;
    did_exec = 1'b0;
    if (last_phase)
    begin
      skip_next = 1'b0;
      if (skip_reg)
      begin
        did_exec = 1'b0;
      end
      else if (instr_valid)
      begin
        did_exec = is_addl | is_addf | is_andl | is_andf | is_bclr | is_bset
          | is_skz | is_sko;
        if (is_addl)
        begin
          acc_next = alu_res;
          flags_next = {alu_z, alu_hc, alu_c};
        end
        else if (is_addf)
        begin
          flags_next = {alu_z, alu_hc, alu_c};
          if (dest)
          begin
            file_we = 1'b1;
            file_wdata = alu_res;
          end
          else
          begin
            acc_next = alu_res;
          end
        end
        else if (is_andl)
        begin
          acc_next = alu_res;
          flags_next[`AAB_FLAG_Z] = alu_z;
        end
        else if (is_andf)
        begin
          flags_next[`AAB_FLAG_Z] = alu_z;
          if (dest)
          begin
            file_we = 1'b1;
            file_wdata = alu_res;
          end
          else
          begin
            acc_next = alu_res;
          end
        end
        else if (is_bclr)
        begin
          file_we = 1'b1;
          file_wdata = fval & ~(8'h01 << bsel);
        end
        else if (is_bset)
        begin
          file_we = 1'b1;
          file_wdata = fval | (8'h01 << bsel);
        end
        else if (is_sko)
        begin
          skip_next = tested_bit;
        end
        else if (is_skz)
        begin
          skip_next = ~tested_bit;
        end
      end
    end
  end

  // four-phase instruction cycle counter
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      phase_reg <= 2'h0;
    else
      phase_reg <= phase_reg + 2'h1;
  end

  // accumulator, flags, skip state and status outputs
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      acc_out <= `AAB_ACC_RESET;
      flags_out <= `AAB_FLAGS_RESET;
      skip_reg <= 1'b0;
      skip_active <= 1'b0;
      cycle_end <= 1'b0;
      exec_done <= 1'b0;
      wr_addr <= 7'h00;
      wr_data <= 8'h00;
      wr_strobe <= 1'b0;
    end
    else
    begin
      acc_out <= acc_next;
      flags_out <= flags_next;
      skip_reg <= skip_next;
      skip_active <= skip_next;
      cycle_end <= last_phase;
      exec_done <= did_exec;
      wr_strobe <= file_we;
      if (file_we)
      begin
        wr_addr <= fsel;
        wr_data <= file_wdata;
      end
    end
  end

  // file register array, no reset; contents start undefined
  // so a bit test before any write of that byte sees an unknown bit
  always @(posedge clock)
  begin
    if (file_we)
      file_mem[fsel] <= file_wdata;
  end
endmodule // aab_core

// ### bench/aab_core_props.sv
/* port assertions for aab_core
   assumes one clock and resetn async active low */
`timescale 1ns/1ns
module aab_core_props (
  input wire clock, // core clock
  input wire resetn, // reset, active low
  input wire [13:0] instr, // instruction
  input wire instr_valid, // valid
  input wire [7:0] acc_out, // accumulator
  input wire [2:0] flags_out, // flags
  input wire cycle_end, // cycle pulse
  input wire skip_active, // no-op cycle
  input wire exec_done, // executed
  input wire [6:0] wr_addr, // write address
  input wire [7:0] wr_data, // write data
  input wire wr_strobe // write pulse
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // a forced no-op cycle that has just ended
  sequence s_skip_over;
    skip_active ##1 !skip_active;
  endsequence
  a_cycle_four: assert property (cycle_end |=> !cycle_end [*3] ##1 cycle_end)
    else $error("cycle_end not every four clocks");
  a_skip_len: assert property ($rose(skip_active) |-> skip_active [*4])
    else $error("skip cycle shorter than four clocks");
  a_skip_void: assert property (s_skip_over |-> !exec_done)
    else $error("skipped instruction took effect");
  a_wr_single: assert property (wr_strobe |=> !wr_strobe [*3])
    else $error("file write more than once a cycle");
  a_wr_exec: assert property (wr_strobe |-> exec_done)
    else $error("file write without execution");
  a_acc_hold: assert property (!exec_done |-> $stable(acc_out) && $stable(flags_out))
    else $error("acc or flags moved with no execution");
  a_done_end: assert property (exec_done |-> cycle_end)
    else $error("execution off the cycle end");
  a_zero_flag: assert property ($changed(acc_out) |-> flags_out[2] == (acc_out == 8'h00))
    else $error("zero flag disagrees with acc");
endmodule // aab_core_props
bind aab_core aab_core_props u_props (.clock(clock), .resetn(resetn), .instr(instr),
  .instr_valid(instr_valid), .acc_out(acc_out), .flags_out(flags_out),
  .cycle_end(cycle_end), .skip_active(skip_active), .exec_done(exec_done),
  .wr_addr(wr_addr), .wr_data(wr_data), .wr_strobe(wr_strobe));

// ### bench/aab_core_tb.sv
/* self-checking bench for aab_core
   assumes one instruction per four clocks, inputs set at falling edges */
`timescale 1ns/1ns
module aab_core_tb;
  reg clock;
  reg resetn;
  reg [13:0] instr;
  reg instr_valid;
  reg [7:0] ea;
  reg [2:0] ef;
  wire [7:0] acc_out;
  wire [2:0] flags_out;
  wire cycle_end;
  wire skip_active;
  wire exec_done;
  wire [6:0] wr_addr;
  wire [7:0] wr_data;
  wire wr_strobe;
  integer fails;
  integer comparisons;
  aab_core u_dut (.clock(clock), .resetn(resetn), .instr(instr), .instr_valid(instr_valid),
    .acc_out(acc_out), .flags_out(flags_out), .cycle_end(cycle_end),
    .skip_active(skip_active), .exec_done(exec_done), .wr_addr(wr_addr),
    .wr_data(wr_data), .wr_strobe(wr_strobe));
  // 50 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task summarize;
  begin
    if (fails == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask
  task chk(input [39:0] name, input [7:0] exp, input [7:0] got);
  begin
    comparisons = comparisons + 1;
    if (exp !== got)
    begin
      fails = fails + 1;
      $display("wrong value %0s expected %h seen %h", name, exp, got);
    end
  end
  endtask
  // one instruction cycle, then acc and {flags, done, skip}
  task ex(input [13:0] i, input [7:0] a, input [2:0] f, input d, input s);
  begin
    instr = i;
    instr_valid = 1'b1;
    repeat (4) @(posedge clock);
    @(negedge clock);
    ea = a;
    ef = f;
    chk("acc", a, acc_out);
    chk("stat", {2'h0, f, d, s, 1'b1}, {2'h0, flags_out, exec_done, skip_active, cycle_end});
  end
  endtask
  // build a file byte bit by bit
  task ld(input [6:0] fa, input [7:0] v);
    integer b;
  begin
    for (b = 0; b < 8; b = b + 1)
      ex({3'h2, v[b], b[2:0], fa}, ea, ef, 1'b1, 1'b0);
    chk("wdata", v, wr_data);
    chk("waddr", {1'b0, fa}, {1'b0, wr_addr});
    chk("wstb", 8'h01, {7'h00, wr_strobe});
  end
  endtask
  task t_bit_ops;
  begin
    ld(7'h7f, 8'ha5);
    ld(7'h12, 8'h3c);
  end
  endtask
  task t_lit_ops;
  begin
    ex({6'h3e, 8'h81}, 8'h81, 3'h0, 1'b1, 1'b0);
    ex({6'h3e, 8'hff}, 8'h80, 3'h3, 1'b1, 1'b0);
    ex({6'h39, 8'h80}, 8'h80, 3'h3, 1'b1, 1'b0);
    ex({6'h39, 8'h7f}, 8'h00, 3'h7, 1'b1, 1'b0);
    ex({6'h3e, 8'h0f}, 8'h0f, 3'h0, 1'b1, 1'b0);
  end
  endtask
  task t_file_ops;
  begin
    ex({6'h07, 1'b0, 7'h12}, 8'h4b, 3'h2, 1'b1, 1'b0);
    ex({6'h07, 1'b1, 7'h12}, 8'h4b, 3'h2, 1'b1, 1'b0);
    chk("wdata", 8'h87, wr_data);
    ex({6'h05, 1'b0, 7'h12}, 8'h03, 3'h2, 1'b1, 1'b0);
    ex({6'h05, 1'b1, 7'h12}, 8'h03, 3'h2, 1'b1, 1'b0);
    chk("wdata", 8'h03, wr_data);
  end
  endtask
  // file 0x12 holds 0x03 here
  task t_skips;
  begin
    ex({4'h7, 3'd1, 7'h12}, 8'h03, 3'h2, 1'b1, 1'b1);
    ex({6'h3e, 8'h01}, 8'h03, 3'h2, 1'b0, 1'b0);
    ex({4'h6, 3'd2, 7'h12}, 8'h03, 3'h2, 1'b1, 1'b1);
    ex({6'h3e, 8'h01}, 8'h03, 3'h2, 1'b0, 1'b0);
    ex({4'h7, 3'd7, 7'h12}, 8'h03, 3'h2, 1'b1, 1'b0);
    ex({6'h3e, 8'h01}, 8'h04, 3'h0, 1'b1, 1'b0);
    ex({4'h6, 3'd0, 7'h12}, 8'h04, 3'h0, 1'b1, 1'b0);
  end
  endtask
  // an instruction word without its valid flag does nothing
  task t_idle;
  begin
    instr = {6'h3e, 8'h01};
    instr_valid = 1'b0;
    repeat (4) @(posedge clock);
    @(negedge clock);
    chk("acc", 8'h04, acc_out);
    chk("done", 8'h00, {7'h00, exec_done});
  end
  endtask
  // reset, then the scenarios
  initial
  begin
    fails = 0;
    comparisons = 0;
    ea = 8'h00;
    ef = 3'h0;
    resetn = 1'b0;
    instr = 14'h0000;
    instr_valid = 1'b0;
    repeat (20) @(negedge clock);
    resetn = 1'b1;
    t_bit_ops;
    t_lit_ops;
    t_file_ops;
    t_skips;
    t_idle;
    summarize;
  end
  // watchdog against a hang
  initial
  begin
    #20000;
    fails = fails + 1;
    summarize;
  end
endmodule // aab_core_tb
